// ===== rtl/pmc_power_mode_ctrl.sv
// Power-mode controller: sequences active, idle, standby, shutdown and reset-held states.
// Assumes all inputs synchronous to clk_sys; analogue blocks act on the enable outputs.
// Function
// - Four software modes plus a separate state while reset pin is held.
// - Idle gates the CPU clock; flash and SRAM stay enabled; any interrupt returns to active.
// - Wake latency 14 us idle, 151 us standby, 1015 us shutdown/reset pin.
// - Standby keeps always-on domain, sensor controller and SRAM; wakes on pin, RTC, sensor event.
// - Standby exit resumes CPU where it stopped; retained peripherals keep state.
// - All GPIO outputs are latched while in standby.
// - Shutdown powers everything off except power-on detection, and keeps pre-shutdown I/O levels.
// - Shutdown wake pin level change wakes device as a reset trigger.
// - Readable reset cause distinguishes shutdown wake, reset pin and power-on.
// - Across shutdown only I/O levels and flash survive; registers, SRAM lost.
// - RTC wakes in active/idle/standby only; pins also in shutdown; reset always.
// - Brown-out on in active/idle, duty-cycled in standby, off in shutdown.
// - Fast clock from 24 MHz crystal doubled to 48 MHz.
// - Sleep with a live link only if slow clock better than 500 ppm.
// - Without slow crystal use 32.768 kHz internal osc; fast internal osc allowed.
// - Always-on domain and RTC stay powered in all modes except shutdown.
// - RTC has three compares and one capture; compare wakes where RTC runs.
// - Sensor controller runs alone, stays up in standby, can wake the CPU.
`timescale 1ns/1ps
module pmc_power_mode_ctrl
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic por_event,
   // Software request
   input wire logic sleep_req,
   input wire pmc_pkg::pmc_mode_e sleep_mode,
   input wire logic link_active,
   input wire logic [9:0] slow_ppm,
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] shutdown_wake_en,
   // Wake sources
   input wire logic irq_any,
   input wire logic [pmc_pkg::PMC_RTC_CMP_N-1:0] rtc_cmp_hit,
   input wire logic sensor_wake,
   input wire logic pin_edge_wake,
   input wire logic reset_pin,
   // Oscillators
   input wire logic slow_crystal_fitted,
   input wire logic fast_crystal_stable,
   input wire logic use_fast_internal,
   // I/O
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_out_core,
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_in,
   output logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_out_pad,
   // Domain enables
   output logic cpu_clk_en_q,
   output logic flash_en_q,
   output logic sram_en_q,
   output logic periph_en_q,
   output logic radio_en_q,
   output logic always_on_domain_en_q,
   output logic sensor_ctrl_en_q,
   output logic brownout_detector_en_q,
   output logic por_detect_en_q,
   output logic core_reset_q,
   // Clocks
   output logic fast_crystal_osc_en_q,
   output logic fast_doubler_en_q,
   output logic fast_internal_osc_sel_q,
   output logic slow_crystal_osc_en_q,
   output logic slow_internal_osc_en_q,
   // Status
   output pmc_pkg::pmc_state_e state_q,
   output logic [1:0] reset_cause_q,
   output logic sleep_refused_q,
   output logic io_latched_q
);
   import pmc_pkg::*;

   pmc_state_e state_d;
   pmc_state_e wake_from_q;
   logic [PMC_CNT_W-1:0] wake_cnt_q;
   logic [PMC_BOD_DUTY_W-1:0] bod_div_q;
   logic [PMC_GPIO_W-1:0] gpio_in_snap_q;
   logic [1:0] reset_cause_d;
   logic io_hold;

   // Wake decode per state
   wire rtc_wake = |rtc_cmp_hit;
   wire standby_wake = pin_edge_wake | rtc_wake | sensor_wake;
   wire shut_wake = |((gpio_in ^ gpio_in_snap_q) & shutdown_wake_en);
   wire idle_wake = irq_any | rtc_wake | sensor_wake | pin_edge_wake;
   wire clk_ok_sleep = !link_active || (slow_ppm < PMC_SLOW_PPM_MAX);
   wire sleep_ok = sleep_req && clk_ok_sleep && (sleep_mode != PMC_MODE_ACTIVE);
   wire deep_wake = (wake_from_q != PMC_ST_IDLE);
   wire [PMC_CNT_W-1:0] wake_len = (wake_from_q == PMC_ST_IDLE) ? PMC_CNT_W'(PMC_WAKE_IDLE_CYC) :
      (wake_from_q == PMC_ST_STANDBY) ? PMC_CNT_W'(PMC_WAKE_STANDBY_CYC) :
      PMC_CNT_W'(PMC_WAKE_SHUTDOWN_CYC);
   wire wake_done = (wake_cnt_q >= wake_len - PMC_CNT_W'(1)) && (!deep_wake || fast_crystal_stable);
   wire in_deep = (state_q == PMC_ST_STANDBY) || (state_q == PMC_ST_SHUTDOWN);

   // Next-state logic
   always_comb begin
      state_d = state_q;
      reset_cause_d = reset_cause_q;
      case (state_q)
         PMC_ST_ACTIVE: begin
            if (sleep_ok) begin
               case (sleep_mode)
                  PMC_MODE_IDLE: state_d = PMC_ST_IDLE;
                  PMC_MODE_STANDBY: state_d = PMC_ST_STANDBY;
                  default: state_d = PMC_ST_SHUTDOWN;
               endcase
            end
         end
         PMC_ST_IDLE: if (idle_wake) state_d = PMC_ST_WAKE;
         PMC_ST_STANDBY: if (standby_wake) state_d = PMC_ST_WAKE;
         PMC_ST_SHUTDOWN: begin
            if (shut_wake) begin
               state_d = PMC_ST_WAKE;
               reset_cause_d = PMC_CAUSE_SHUTDOWN_WAKE;
            end
         end
         PMC_ST_WAKE: if (wake_done) state_d = PMC_ST_ACTIVE;
         PMC_ST_RESET_HELD: if (!reset_pin) state_d = PMC_ST_WAKE;
         default: state_d = PMC_ST_ACTIVE;
      endcase
      // Reset pin wins from every state, including reset-held; only a power-on event in the same cycle overrides it
      if (reset_pin) begin
         state_d = PMC_ST_RESET_HELD;
         reset_cause_d = PMC_CAUSE_PIN;
      end
      if (por_event) begin
         state_d = PMC_ST_WAKE;
         reset_cause_d = PMC_CAUSE_POR;
      end
   end

   // State and cause registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= PMC_ST_WAKE;
         reset_cause_q <= PMC_CAUSE_POR;
      end else begin
         state_q <= state_d;
         reset_cause_q <= reset_cause_d;
      end
   end

   // Wake origin and latency counter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wake_from_q <= PMC_ST_SHUTDOWN;
         wake_cnt_q <= '0;
      end else begin
         // A power-on event restarts the full wake even when one is already running
         if (por_event || (state_q != PMC_ST_WAKE && state_d == PMC_ST_WAKE)) begin
            wake_from_q <= (state_q == PMC_ST_RESET_HELD || por_event) ? PMC_ST_SHUTDOWN : state_q;
            wake_cnt_q <= '0;
         end else if (state_q == PMC_ST_WAKE && wake_cnt_q != '1) begin
            wake_cnt_q <= wake_cnt_q + PMC_CNT_W'(1);
         end
      end
   end

   // Sleep refusal flag and snapshot of pin levels for shutdown wake
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sleep_refused_q <= 1'b0;
         gpio_in_snap_q <= '0;
      end else begin
         if (state_q == PMC_ST_ACTIVE && sleep_req) begin
            sleep_refused_q <= !clk_ok_sleep;
         end
         if (state_q == PMC_ST_ACTIVE) begin
            gpio_in_snap_q <= gpio_in;
         end
      end
   end

   // Duty-cycle divider for the brown-out detector in standby
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bod_div_q <= '0;
      end else begin
         bod_div_q <= bod_div_q + PMC_BOD_DUTY_W'(1);
      end
   end

   // I/O hold in standby and shutdown
   assign io_hold = in_deep;
   pmc_hold_latch #(
      .WIDTH(PMC_GPIO_W)
   ) u_io_hold (
      .clk_sys(clk_sys),
      .reset(reset),
      .hold(io_hold),
      .din(gpio_out_core),
      .dout(gpio_out_pad)
   );

   // Domain and clock enables per state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cpu_clk_en_q <= 1'b0;
         flash_en_q <= 1'b0;
         sram_en_q <= 1'b0;
         periph_en_q <= 1'b0;
         radio_en_q <= 1'b0;
         always_on_domain_en_q <= 1'b1;
         sensor_ctrl_en_q <= 1'b1;
         brownout_detector_en_q <= 1'b1;
         por_detect_en_q <= 1'b1;
         core_reset_q <= 1'b1;
         fast_crystal_osc_en_q <= 1'b0;
         fast_doubler_en_q <= 1'b0;
         fast_internal_osc_sel_q <= 1'b1;
         slow_crystal_osc_en_q <= 1'b0;
         slow_internal_osc_en_q <= 1'b1;
         io_latched_q <= 1'b0;
      end else begin
         // CPU clock only in active; idle stops the CPU clock, flash and SRAM stay enabled
         cpu_clk_en_q <= (state_d == PMC_ST_ACTIVE);
         flash_en_q <= (state_d == PMC_ST_ACTIVE) || (state_d == PMC_ST_IDLE);
         // SRAM retained in standby, lost in shutdown and reset-held
         sram_en_q <= (state_d != PMC_ST_SHUTDOWN) && (state_d != PMC_ST_RESET_HELD);
         periph_en_q <= (state_d == PMC_ST_ACTIVE) || (state_d == PMC_ST_IDLE);
         radio_en_q <= (state_d == PMC_ST_ACTIVE) || (state_d == PMC_ST_IDLE);
         always_on_domain_en_q <= (state_d != PMC_ST_SHUTDOWN) && (state_d != PMC_ST_RESET_HELD);
         sensor_ctrl_en_q <= (state_d != PMC_ST_SHUTDOWN) && (state_d != PMC_ST_RESET_HELD);
         brownout_detector_en_q <= (state_d == PMC_ST_STANDBY) ? (bod_div_q == '0) :
            (state_d != PMC_ST_SHUTDOWN) && (state_d != PMC_ST_RESET_HELD);
         por_detect_en_q <= (state_d != PMC_ST_RESET_HELD);
         // Core held in reset from shutdown or pin until wake completes; standby keeps state
         core_reset_q <= (state_d == PMC_ST_RESET_HELD) || (state_d == PMC_ST_SHUTDOWN) ||
            ((state_d == PMC_ST_WAKE) && (wake_from_q == PMC_ST_SHUTDOWN));
         // Fast clock restarts during deep wake; doubler follows the crystal
         fast_crystal_osc_en_q <= (state_d == PMC_ST_ACTIVE) || (state_d == PMC_ST_IDLE) ||
            (state_d == PMC_ST_WAKE);
         fast_doubler_en_q <= fast_crystal_stable && ((state_d == PMC_ST_ACTIVE) ||
            (state_d == PMC_ST_IDLE));
         fast_internal_osc_sel_q <= use_fast_internal || !fast_crystal_stable;
         slow_crystal_osc_en_q <= slow_crystal_fitted && (state_d != PMC_ST_SHUTDOWN) &&
            (state_d != PMC_ST_RESET_HELD);
         slow_internal_osc_en_q <= !slow_crystal_fitted && (state_d != PMC_ST_SHUTDOWN) &&
            (state_d != PMC_ST_RESET_HELD);
         io_latched_q <= (state_d == PMC_ST_STANDBY) || (state_d == PMC_ST_SHUTDOWN);
      end
   end
endmodule

// ===== rtl/pmc_pkg.sv
// Package for the power-mode controller: modes, states, reset causes and timing.
// Assumes a single 25 MHz system clock; all latencies are converted to cycles here.
package pmc_pkg;

   // Software-selectable target modes
   typedef enum logic [1:0] {PMC_MODE_ACTIVE, PMC_MODE_IDLE, PMC_MODE_STANDBY, PMC_MODE_SHUTDOWN} pmc_mode_e;

   // Controller states; the reset-held state is separate from the software modes
   typedef enum logic [2:0] {PMC_ST_ACTIVE, PMC_ST_IDLE, PMC_ST_STANDBY, PMC_ST_SHUTDOWN,
      PMC_ST_RESET_HELD, PMC_ST_WAKE} pmc_state_e;

   // Reset cause codes
   localparam logic [1:0] PMC_CAUSE_POR = 2'h0;
   localparam logic [1:0] PMC_CAUSE_PIN = 2'h1;
   localparam logic [1:0] PMC_CAUSE_SHUTDOWN_WAKE = 2'h2;

   // Clock and wake latencies
   localparam int PMC_CLK_HZ = 25000000;
   localparam int PMC_CLK_NS = 40;
   localparam int PMC_WAKE_IDLE_NS = 14000;
   localparam int PMC_WAKE_STANDBY_NS = 151000;
   localparam int PMC_WAKE_SHUTDOWN_NS = 1015000;
   localparam int PMC_WAKE_IDLE_CYC = PMC_WAKE_IDLE_NS / PMC_CLK_NS;
   localparam int PMC_WAKE_STANDBY_CYC = PMC_WAKE_STANDBY_NS / PMC_CLK_NS;
   localparam int PMC_WAKE_SHUTDOWN_CYC = PMC_WAKE_SHUTDOWN_NS / PMC_CLK_NS;
   localparam int PMC_CNT_W = 16;

   // Clock references and accuracy limit
   localparam int PMC_FAST_REF_HZ = 24000000;
   localparam int PMC_FAST_MULT = 2;
   localparam int PMC_FAST_OUT_HZ = PMC_FAST_REF_HZ * PMC_FAST_MULT;
   localparam int PMC_SLOW_INT_HZ = 32768;
   localparam logic [9:0] PMC_SLOW_PPM_MAX = 10'h1F4;

   // Widths
   localparam int PMC_GPIO_W = 31;
   localparam int PMC_RTC_CMP_N = 3;
   localparam int PMC_BOD_DUTY_W = 8;

endpackage

// ===== rtl/pmc_hold_latch.sv
// Holdable register bank for the I/O levels that must survive deep sleep.
// Assumes the hold input is a clean synchronous level from the controller.
`timescale 1ns/1ps
module pmc_hold_latch #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Data
   input wire logic hold,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // Follow input until hold, then freeze
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dout <= '0;
      end else if (!hold) begin
         dout <= din;
      end
   end
endmodule

// ===== testbench/pmc_checker.sv
// Checker for the power-mode controller: mode entry, domain enables, I/O hold, wake latency.
// Assumes it is bound to pmc_power_mode_ctrl, which has one clock and a synchronous reset.
`timescale 1ns/1ps
module pmc_checker
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys, reset,
   // Inputs
   input wire logic por_event, sleep_req, link_active, reset_pin, slow_crystal_fitted, fast_crystal_stable,
   input wire pmc_pkg::pmc_mode_e sleep_mode,
   input wire logic [9:0] slow_ppm,
   // Outputs
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_out_pad,
   input wire logic cpu_clk_en_q, flash_en_q, sram_en_q, always_on_domain_en_q, sensor_ctrl_en_q,
   input wire logic brownout_detector_en_q, por_detect_en_q, slow_internal_osc_en_q, sleep_refused_q,
   input wire pmc_pkg::pmc_state_e state_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [15:0] cnt_q;
   pmc_state_e org_q;
   // Cycles spent waking, and the state the wake began in
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_q <= 16'h0;
         org_q <= PMC_ST_SHUTDOWN;
      end else begin
         cnt_q <= (state_q == PMC_ST_WAKE) ? cnt_q + 16'h1 : 16'h0;
         if (state_q != PMC_ST_WAKE) org_q <= state_q;
      end
   end
   // Steps of a wake and of a sleep request
   sequence s_wake_exit;
      $past(state_q) == PMC_ST_WAKE && state_q == PMC_ST_ACTIVE;
   endsequence
   sequence s_sleep_req;
      sleep_req && state_q == PMC_ST_ACTIVE && sleep_mode != PMC_MODE_ACTIVE && !reset_pin && !por_event;
   endsequence
   a_sleep_taken: assert property (s_sleep_req ##0 (!link_active || slow_ppm < PMC_SLOW_PPM_MAX)
      |=> state_q == {1'b0, $past(sleep_mode)}) else $error("sleep request not taken");
   a_sleep_refused: assert property (s_sleep_req ##0 (link_active && slow_ppm >= PMC_SLOW_PPM_MAX)
      |=> state_q == PMC_ST_ACTIVE && sleep_refused_q) else $error("inaccurate sleep not refused");
   a_pin_held: assert property (reset_pin && !por_event |=> state_q == PMC_ST_RESET_HELD)
      else $error("reset pin not held");
   a_idle_gating: assert property (state_q == PMC_ST_IDLE |-> !cpu_clk_en_q && sram_en_q)
      else $error("cpu clocked in idle");
   a_standby_domains: assert property (state_q == PMC_ST_STANDBY |-> always_on_domain_en_q
      && sensor_ctrl_en_q && sram_en_q && !flash_en_q && !cpu_clk_en_q) else $error("standby enables wrong");
   a_shutdown_off: assert property (state_q == PMC_ST_SHUTDOWN |-> por_detect_en_q
      && !(always_on_domain_en_q || sensor_ctrl_en_q || brownout_detector_en_q || sram_en_q))
      else $error("shutdown enables wrong");
   a_io_hold: assert property (state_q inside {PMC_ST_STANDBY, PMC_ST_SHUTDOWN} [*2]
      |-> $stable(gpio_out_pad)) else $error("pads moved in deep sleep");
   a_active_run: assert property (state_q == PMC_ST_ACTIVE |-> cpu_clk_en_q && flash_en_q
      && brownout_detector_en_q && (slow_crystal_fitted || slow_internal_osc_en_q)) else $error("active wrong");
   a_idle_latency: assert property (s_wake_exit ##0 org_q == PMC_ST_IDLE
      |-> cnt_q >= 16'd349 && cnt_q <= 16'd351) else $error("idle wake latency wrong");
   a_deep_latency: assert property (s_wake_exit ##0 org_q != PMC_ST_IDLE |-> $past(fast_crystal_stable)
      && cnt_q >= (org_q == PMC_ST_STANDBY ? 16'd3775 : 16'd25375)) else $error("deep wake too early");
endmodule
bind pmc_power_mode_ctrl pmc_checker u_chk (.clk_sys, .reset, .por_event, .sleep_req, .link_active, .reset_pin,
   .slow_crystal_fitted, .fast_crystal_stable, .sleep_mode, .slow_ppm, .gpio_out_pad, .cpu_clk_en_q, .flash_en_q,
   .sram_en_q, .always_on_domain_en_q, .sensor_ctrl_en_q, .brownout_detector_en_q, .por_detect_en_q,
   .slow_internal_osc_en_q, .sleep_refused_q, .state_q);

// ===== testbench/pmc_pad_model.sv
// Pad model: each pin shows its driven level unless the outside world flips it.
// Assumes flips come from the bench between clock edges.
`timescale 1ns/1ps
module pmc_pad_model
   import pmc_pkg::*;
(
   // Pins
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_out_pad,
   input wire logic [pmc_pkg::PMC_GPIO_W-1:0] ext_flip,
   output logic [pmc_pkg::PMC_GPIO_W-1:0] gpio_in
);
   // Outside drive flips the latched level on chosen pins
   assign gpio_in = gpio_out_pad ^ ext_flip;
endmodule

// ===== testbench/power_mode_controller_tb.sv
// Testbench for the power-mode controller: entry, refusal, wake sources, pad hold, reset cause.
// Assumes the pad model stands for the pins and the checker is bound to the controller.
`timescale 1ns/1ps
module power_mode_controller_tb;
   import pmc_pkg::*;
   logic clk_sys = 1'b0, reset = 1'b1, por_event = 1'b0, sleep_req = 1'b0, link_active = 1'b0, frz = 1'b0;
   logic slow_crystal_fitted = 1'b0, fast_crystal_stable = 1'b1, use_fast_internal = 1'b0, reset_pin = 1'b0;
   pmc_mode_e sleep_mode = PMC_MODE_ACTIVE;
   logic [9:0] slow_ppm = 10'h0;
   logic [5:0] wv = 6'h0;
   logic [PMC_GPIO_W-1:0] shutdown_wake_en = 31'h8, gpio_out_core = 31'h0, ext_flip = 31'h0, gpio_in, gpio_out_pad, pad_s;
   logic cpu_clk_en_q, flash_en_q, sram_en_q, periph_en_q, radio_en_q, always_on_domain_en_q, sensor_ctrl_en_q;
   logic brownout_detector_en_q, por_detect_en_q, core_reset_q, fast_crystal_osc_en_q, fast_doubler_en_q;
   logic fast_internal_osc_sel_q, slow_crystal_osc_en_q, slow_internal_osc_en_q, sleep_refused_q, io_latched_q;
   logic [1:0] reset_cause_q;
   pmc_state_e state_q;
   integer seed = 32'hC19227D9;
   int n_fail = 0, comparisons = 0, n, k;
   always #20 clk_sys = ~clk_sys;
   pmc_power_mode_ctrl dut (.clk_sys, .reset, .por_event, .sleep_req, .sleep_mode, .link_active, .slow_ppm,
      .shutdown_wake_en, .irq_any(wv[0]), .rtc_cmp_hit(wv[3:1]), .sensor_wake(wv[4]), .pin_edge_wake(wv[5]),
      .reset_pin, .slow_crystal_fitted, .fast_crystal_stable, .use_fast_internal, .gpio_out_core, .gpio_in,
      .gpio_out_pad, .cpu_clk_en_q, .flash_en_q, .sram_en_q, .periph_en_q, .radio_en_q, .always_on_domain_en_q,
      .sensor_ctrl_en_q, .brownout_detector_en_q, .por_detect_en_q, .core_reset_q, .fast_crystal_osc_en_q,
      .fast_doubler_en_q, .fast_internal_osc_sel_q, .slow_crystal_osc_en_q, .slow_internal_osc_en_q, .state_q,
      .reset_cause_q, .sleep_refused_q, .io_latched_q);
   pmc_pad_model pads (.gpio_out_pad, .ext_flip, .gpio_in);
   // Clock steps; core outputs wander at random unless frozen
   task automatic step(input int c);
      repeat (c) begin
         @(posedge clk_sys);
         #1;
         if (!frz) gpio_out_core = PMC_GPIO_W'($random(seed));
      end
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_st(input pmc_state_e st, input int bound);
      n = 0;
      while (state_q !== st && n < bound) begin
         step(1);
         n++;
      end
      if (state_q !== st) begin
         n_fail++;
         $display("wrong value at %0t ns: state wait ran out", $time);
         wrap_up();
      end
   endtask
   // Expected wake latency in cycles for the state a wake starts from
   function automatic int lat(input pmc_state_e from);
      if (from == PMC_ST_IDLE) return PMC_WAKE_IDLE_CYC;
      return (from == PMC_ST_STANDBY) ? PMC_WAKE_STANDBY_CYC : PMC_WAKE_SHUTDOWN_CYC;
   endfunction
   task automatic go(input pmc_mode_e m);
      sleep_mode = m;
      step(1);
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
   endtask
   task automatic wake(input logic [5:0] v, input logic [PMC_GPIO_W-1:0] f, input pmc_state_e from);
      wv = v;
      ext_flip = f;
      step(1);
      wv = 6'h0;
      wait_st(PMC_ST_ACTIVE, lat(from) + 100);
      check(n + 1 >= lat(from) && n <= lat(from) + 8, 1);
   endtask
   initial begin
      step(12);
      check({core_reset_q, cpu_clk_en_q, reset_cause_q}, {1'b1, 1'b0, PMC_CAUSE_POR});
      reset = 1'b0;
      wait_st(PMC_ST_ACTIVE, lat(PMC_ST_SHUTDOWN) + 100);
      // Live link with a too coarse slow clock, then just fine enough
      link_active = 1'b1;
      slow_ppm = 10'h1F4;
      go(PMC_MODE_IDLE);
      check({state_q, sleep_refused_q}, {PMC_ST_ACTIVE, 1'b1});
      slow_ppm = 10'h1F3;
      for (k = 0; k < 6; k++) begin
         go(PMC_MODE_IDLE);
         check({state_q, cpu_clk_en_q, sleep_refused_q}, {PMC_ST_IDLE, 2'b00});
         check({periph_en_q, radio_en_q, flash_en_q, io_latched_q}, 4'b1110);
         wake(6'h1 << k, ext_flip, PMC_ST_IDLE);
      end
      // Standby ignores interrupts and holds the pads
      link_active = 1'b0;
      go(PMC_MODE_STANDBY);
      step(1);
      pad_s = gpio_out_pad;
      wv = 6'h1;
      step(20);
      check(state_q, PMC_ST_STANDBY);
      check(gpio_out_pad, pad_s);
      check({io_latched_q, periph_en_q, radio_en_q, fast_crystal_osc_en_q}, 4'b1000);
      wake(6'h10, ext_flip, PMC_ST_STANDBY);
      go(PMC_MODE_STANDBY);
      wake(6'h8, ext_flip, PMC_ST_STANDBY);
      // Standby with the slow crystal fitted; the wake then waits for a stable fast clock
      go(PMC_MODE_STANDBY);
      slow_crystal_fitted = 1'b1;
      k = 0;
      repeat (256) begin
         step(1);
         k += brownout_detector_en_q;
      end
      check(k, 1);
      check({slow_crystal_osc_en_q, slow_internal_osc_en_q, io_latched_q, periph_en_q}, 4'b1010);
      slow_crystal_fitted = 1'b0;
      fast_crystal_stable = 1'b0;
      wv = 6'h20;
      step(1);
      wv = 6'h0;
      step(lat(PMC_ST_STANDBY) + 10);
      check({state_q, cpu_clk_en_q, fast_crystal_osc_en_q, fast_internal_osc_sel_q}, {PMC_ST_WAKE, 3'b011});
      fast_crystal_stable = 1'b1;
      use_fast_internal = 1'b1;
      step(2);
      check({state_q, cpu_clk_en_q, fast_doubler_en_q, fast_internal_osc_sel_q}, {PMC_ST_ACTIVE, 3'b111});
      use_fast_internal = 1'b0;
      // Shutdown: timer, sensor and unarmed pins do nothing; the armed pin resets
      frz = 1'b1;
      step(2);
      go(PMC_MODE_SHUTDOWN);
      step(1);
      pad_s = gpio_out_pad;
      wv = 6'h1F;
      ext_flip = 31'h4;
      step(20);
      check(state_q, PMC_ST_SHUTDOWN);
      check(gpio_out_pad, pad_s);
      check({io_latched_q, slow_internal_osc_en_q, fast_crystal_osc_en_q, core_reset_q}, 4'b1001);
      wake(6'h0, 31'hC, PMC_ST_SHUTDOWN);
      check(reset_cause_q, PMC_CAUSE_SHUTDOWN_WAKE);
      // Reset pin held from idle, then released
      frz = 1'b0;
      go(PMC_MODE_IDLE);
      reset_pin = 1'b1;
      step(3);
      check({state_q, core_reset_q}, {PMC_ST_RESET_HELD, 1'b1});
      reset_pin = 1'b0;
      wake(6'h0, ext_flip, PMC_ST_RESET_HELD);
      check(reset_cause_q, PMC_CAUSE_PIN);
      wrap_up();
   end
endmodule
